// >>> dv/test_vsda_link_controller.sv
// bench: rx bands, break, idle, loss, retry, abort
`timescale 1ns/1ps
module test_vsda_link_controller;
   logic                      i_clock, i_rst_n, i_load_valid, i_load_last, i_abort_retry, seen, rec;
   logic                      o_bus_drive, o_load_ready, o_bus_idle, o_tx_busy, o_tx_done, o_tx_lost;
   logic [7:0]                i_load_data, d;
   logic [31:0]               seed;
   int                        n_errors, n_tests, len;
   vsda_pkg::vsda_rx_sym_type o_rx_sym;
   vsda_pkg::vsda_kind_type   exp_q[$], got_q[$];
   wire logic                 node_drive;
   wire logic                 bus_line = o_bus_drive | node_drive;

   vsda_bus_node u_vsda_bus_node (.i_clock(i_clock), .o_drive(node_drive));
   vsda_link_controller #(
      .P_BND_E_CYC(13'h1194), .P_BND_F_CYC(13'h125c), .P_BND_G_CYC(13'h1324), .P_SOF_CYC(13'h1068)
   ) u_vsda_link_controller (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_line(bus_line), .o_bus_drive(o_bus_drive),
      .i_load_valid(i_load_valid), .i_load_data(i_load_data), .i_load_last(i_load_last),
      .o_load_ready(o_load_ready), .i_abort_retry(i_abort_retry), .o_rx_sym(o_rx_sym), .o_bus_idle(o_bus_idle),
      .o_tx_busy(o_tx_busy), .o_tx_done(o_tx_done), .o_tx_lost(o_tx_lost)
   );
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic vsda_pkg::vsda_kind_type band(input int n, input logic act);
      if (n < vsda_pkg::VSDA_BND_B_CYC) return vsda_pkg::VSDA_K_INVALID;
      if (n < vsda_pkg::VSDA_BND_C_CYC) return act ? vsda_pkg::VSDA_K_ONE : vsda_pkg::VSDA_K_ZERO;
      if (n < vsda_pkg::VSDA_BND_D_CYC) return act ? vsda_pkg::VSDA_K_ZERO : vsda_pkg::VSDA_K_ONE;
      return act ? vsda_pkg::VSDA_K_SOF : vsda_pkg::VSDA_K_EOD;
   endfunction
   task automatic check_kind(input string what, input vsda_pkg::vsda_kind_type e, input vsda_pkg::vsda_kind_type g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, e, g);
      end
   endtask
   task automatic check_flag(input string what, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask
   // bounded wait; 0 idle, 1 lost, 2 done
   task automatic await(input int w, input int lim);
      seen = 1'b0;
      for (int k = 0; k < lim && !seen; k++) begin
         @(negedge i_clock);
         seen = ((w == 0) ? o_bus_idle : (w == 1) ? o_tx_lost : o_tx_done) === 1'b1;
      end
   endtask
   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // sampled mid-cycle, clear of the launch edge
   always @(negedge i_clock) begin
      if (o_rx_sym.valid === 1'b1 && exp_q.size() > 0) begin
         check_kind("rx class", exp_q.pop_front(), o_rx_sym.kind);
      end else if (o_rx_sym.valid === 1'b1 && rec && o_rx_sym.kind inside {[4'h1:4'h2], 4'h6}) begin
         got_q.push_back(o_rx_sym.kind);
      end
   end
   initial begin
      repeat (95000) @(posedge i_clock);
      n_errors++;
      results();
   end
   initial begin
      seed = 32'he7bac184;
      {i_rst_n, i_load_valid, i_load_last, i_abort_retry, rec} = 5'h00;
      i_load_data = 8'h00;
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      exp_q.push_back(vsda_pkg::VSDA_K_IDLE);
      await(0, 5100);
      check_flag("idle after reset", 1'b1, seen);
      // band edges of both levels, 6 cycles in or out at random
      for (int i = 0; i < 6; i++) begin
         len = int'((i % 3 == 0) ? vsda_pkg::VSDA_BND_B_CYC :
                    (i % 3 == 1) ? vsda_pkg::VSDA_BND_C_CYC : vsda_pkg::VSDA_BND_D_CYC);
         len += rnd() % 2 ? 6 : -6;
         u_vsda_bus_node.hold(!i[0], len);
         exp_q.push_back(band(len, !i[0]));
      end
      for (int j = 0; j < 2; j++) begin
         u_vsda_bus_node.hold(1'b1, 1000);
         exp_q.push_back(vsda_pkg::VSDA_K_ONE);
         u_vsda_bus_node.hold(1'b0, 4600 + 200 * j);
         exp_q.push_back(j ? vsda_pkg::VSDA_K_EOF_IFS : vsda_pkg::VSDA_K_EOF);
      end
      exp_q.push_back(vsda_pkg::VSDA_K_BREAK);
      u_vsda_bus_node.hold(1'b1, 4600);
      u_vsda_bus_node.hold(1'b0, 100);
      exp_q.push_back(vsda_pkg::VSDA_K_IDLE);
      u_vsda_bus_node.hold(1'b0, 4950);
      check_flag("rx classes seen", 1'b1, exp_q.size() == 0);
      // recessive first bit, beaten by a short passive
      d = 8'(rnd()) | 8'h80;
      @(posedge i_clock);
      i_load_valid <= 1'b1;
      i_load_data <= d;
      i_load_last <= 1'b1;
      @(posedge i_clock);
      i_load_valid <= 1'b0;
      @(posedge bus_line);
      @(negedge bus_line);
      repeat (1600) @(posedge i_clock);
      fork
         u_vsda_bus_node.hold(1'b1, 1600);
         begin
            await(1, 100);
            check_flag("dominant loss", 1'b1, seen);
            check_flag("drive after loss", 1'b0, o_bus_drive);
         end
      join
      u_vsda_bus_node.hold(1'b0, 1);
      await(0, 5100);
      got_q.delete();
      rec = 1'b1;
      await(2, 40000);
      check_flag("retry done", 1'b1, seen);
      repeat (2) @(negedge i_clock);
      check_flag("ready after done", 1'b1, o_load_ready);
      check_flag("symbol count", 1'b1, got_q.size() == 9);
      for (int b = 0; b < 9 && b < got_q.size(); b++) begin
         check_kind("tx symbol", b == 0 ? vsda_pkg::VSDA_K_SOF :
                    (d[8 - b] ? vsda_pkg::VSDA_K_ONE : vsda_pkg::VSDA_K_ZERO), got_q[b]);
      end
      @(posedge i_clock) i_load_valid <= 1'b1;
      @(posedge i_clock) {i_load_valid, i_abort_retry} <= 2'b01;
      @(posedge i_clock) i_abort_retry <= 1'b0;
      repeat (2) @(negedge i_clock);
      check_flag("abort", 1'b0, o_tx_busy);
      results();
   end
endmodule

// >>> dv/vsda_bus_node.sv
// another node on the wired-or bus
`timescale 1ns/1ps
module vsda_bus_node (
   input  wire logic i_clock,  // system clock
   output logic      o_drive   // 1 = pull the bus active
);
   initial o_drive = 1'b0;
   // one bus period of n cycles
   task automatic hold(input logic lvl, input int n);
      @(posedge i_clock);
      o_drive <= lvl;
      repeat (n - 1) @(posedge i_clock);
   endtask
endmodule

// >>> dv/vsda_props.sv
// checks on the link controller ports
`timescale 1ns/1ps
module vsda_props #(
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_BND_E_CYC = vsda_pkg::VSDA_BND_E_CYC,  // break edge
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_BND_G_CYC = vsda_pkg::VSDA_BND_G_CYC,  // idle edge
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_SOF_CYC   = vsda_pkg::VSDA_SOF_CYC     // sent sof
) (
   input wire logic                      i_clock,       // clock
   input wire logic                      i_rst_n,       // reset
   input wire logic                      i_bus_line,    // bus level
   input wire logic                      o_bus_drive,   // own drive
   input wire logic                      o_load_ready,  // loader free
   input wire vsda_pkg::vsda_rx_sym_type o_rx_sym,      // symbol
   input wire logic                      o_bus_idle,    // idle flag
   input wire logic                      o_tx_busy,     // frame held
   input wire logic                      o_tx_done,     // frame sent
   input wire logic                      o_tx_lost      // attempt lost
);
   localparam logic [vsda_pkg::VSDA_CNT_W-1:0] S = vsda_pkg::VSDA_SHORT_CYC;
   localparam logic [vsda_pkg::VSDA_CNT_W-1:0] L = vsda_pkg::VSDA_LONG_CYC;
   // raw run lengths, ahead of the synced view
   logic [15:0] act_cnt;
   logic [15:0] act_top;
   logic [15:0] pas_cnt;
   logic [15:0] drv_cnt;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      act_cnt <= (!i_rst_n || !i_bus_line) ? 16'h0000 : act_cnt + 16'h0001;
      pas_cnt <= (!i_rst_n || i_bus_line) ? 16'h0000 : pas_cnt + 16'h0001;
      drv_cnt <= (!i_rst_n || !o_bus_drive) ? 16'h0000 : drv_cnt + 16'h0001;
      act_top <= i_bus_line ? act_cnt + 16'h0001 : act_top;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_idle_pending;
      o_bus_idle && o_tx_busy && !o_bus_drive;
   endsequence
   sequence s_break_sym;
      o_rx_sym.valid && o_rx_sym.kind == vsda_pkg::VSDA_K_BREAK;
   endsequence
   sequence s_quiet;
      !o_bus_drive ##1 !o_bus_drive;
   endsequence
   a_idle_start: assert property (s_idle_pending |-> ##[1:2] o_bus_drive)
      else $error("no start on idle bus");
   a_break_bound: assert property (act_cnt == P_BND_E_CYC |-> ##[1:6] s_break_sym)
      else $error("break missed");
   a_break_early: assert property (s_break_sym |-> act_top >= P_BND_E_CYC)
      else $error("early break");
   a_idle_bound: assert property (pas_cnt == P_BND_G_CYC |-> ##[1:6] o_bus_idle)
      else $error("idle not reached");
   a_idle_early: assert property (o_bus_idle && !i_bus_line |-> pas_cnt >= P_BND_G_CYC)
      else $error("early idle");
   a_loss_quiet: assert property (o_tx_lost |-> s_quiet)
      else $error("drive after loss");
   a_drive_len: assert property ($fell(o_bus_drive) |->
      (drv_cnt inside {[S-4:S+8], [L-4:L+8], [P_SOF_CYC-4:P_SOF_CYC+8]}) or ##[0:1] o_tx_lost)
      else $error("bad drive length");
   a_ready_quiet: assert property (o_load_ready |-> !o_bus_drive && !o_tx_busy)
      else $error("drive when free");
   a_done_ready: assert property (o_tx_done |-> o_load_ready ##1 !o_tx_done)
      else $error("bad done");
   a_rx_pulse: assert property (o_rx_sym.valid |=> !o_rx_sym.valid)
      else $error("long rx pulse");
endmodule

bind vsda_link_controller vsda_props #(
   .P_BND_E_CYC(P_BND_E_CYC), .P_BND_G_CYC(P_BND_G_CYC), .P_SOF_CYC(P_SOF_CYC)
) u_vsda_props (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_line(i_bus_line), .o_bus_drive(o_bus_drive),
   .o_load_ready(o_load_ready), .o_rx_sym(o_rx_sym), .o_bus_idle(o_bus_idle),
   .o_tx_busy(o_tx_busy), .o_tx_done(o_tx_done), .o_tx_lost(o_tx_lost)
);

// >>> include/vsda_pkg.sv
// constants and types of the vpw symbol decode block
package vsda_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and widths
   localparam int VSDA_CLK_MHZ       = 25;
   localparam int VSDA_CNT_W         = 13;
   localparam int VSDA_FRAME_BYTES   = 12;
   localparam int VSDA_EXTRA_BYTE    = 3;   // index of the fourth byte

   ////////////////////////////////////////////////////////////////////////////
   // band boundaries in microseconds (lower edge of each band)
   localparam int VSDA_BND_B_US      = 34;
   localparam int VSDA_BND_C_US      = 96;
   localparam int VSDA_BND_D_US      = 163;
   localparam int VSDA_BND_E_US      = 239;
   localparam int VSDA_BND_F_US      = 280;
   localparam int VSDA_BND_G_US      = 300;

   // nominal transmit lengths in microseconds
   localparam int VSDA_SHORT_US      = 64;
   localparam int VSDA_LONG_US       = 128;
   localparam int VSDA_SOF_US        = 200;

   ////////////////////////////////////////////////////////////////////////////
   // the same figures as clock counts; integer MHz makes them exact
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_B_CYC = VSDA_CNT_W'(VSDA_BND_B_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_C_CYC = VSDA_CNT_W'(VSDA_BND_C_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_D_CYC = VSDA_CNT_W'(VSDA_BND_D_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_E_CYC = VSDA_CNT_W'(VSDA_BND_E_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_F_CYC = VSDA_CNT_W'(VSDA_BND_F_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_BND_G_CYC = VSDA_CNT_W'(VSDA_BND_G_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_SHORT_CYC = VSDA_CNT_W'(VSDA_SHORT_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_LONG_CYC  = VSDA_CNT_W'(VSDA_LONG_US * VSDA_CLK_MHZ);
   localparam logic [VSDA_CNT_W-1:0] VSDA_SOF_CYC   = VSDA_CNT_W'(VSDA_SOF_US * VSDA_CLK_MHZ);

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [3:0] {
      VSDA_K_INVALID = 4'h0,
      VSDA_K_ZERO    = 4'h1,
      VSDA_K_ONE     = 4'h2,
      VSDA_K_EOD     = 4'h3,
      VSDA_K_EOF     = 4'h4,
      VSDA_K_EOF_IFS = 4'h5,
      VSDA_K_SOF     = 4'h6,
      VSDA_K_BREAK   = 4'h7,
      VSDA_K_IDLE    = 4'h8
   } vsda_kind_type;

   typedef struct packed {
      logic [VSDA_CNT_W-1:0] b;
      logic [VSDA_CNT_W-1:0] c;
      logic [VSDA_CNT_W-1:0] d;
      logic [VSDA_CNT_W-1:0] e;
      logic [VSDA_CNT_W-1:0] f;
      logic [VSDA_CNT_W-1:0] g;
   } vsda_bounds_type;

   typedef struct packed {
      logic          valid;
      vsda_kind_type kind;
   } vsda_rx_sym_type;

   typedef enum logic [4:0] {
      VSDA_ST_IDLE  = 5'h01,
      VSDA_ST_WAIT  = 5'h02,
      VSDA_ST_SOF   = 5'h04,
      VSDA_ST_DATA  = 5'h08,
      VSDA_ST_EXTRA = 5'h10
   } vsda_state_type;

   // a zero is short passive or long active, a one the reverse
   function automatic logic [VSDA_CNT_W-1:0] vsda_nominal(input logic bit_val, input logic active);
      return (bit_val ^ active) ? VSDA_LONG_CYC : VSDA_SHORT_CYC;
   endfunction

endpackage

// >>> logic/vsda_band_classifier.sv
// sorts a finished bus period into its symbol class by length
`timescale 1ns/1ps
module vsda_band_classifier (
   input  wire logic [vsda_pkg::VSDA_CNT_W-1:0] i_count,   // length of the period in cycles
   input  wire logic                            i_active,  // period was active
   input  wire vsda_pkg::vsda_bounds_type       i_bounds,  // band lower edges
   output vsda_pkg::vsda_kind_type              o_kind     // symbol class
);

   // bands abut: each ends one cycle below the next
   always_comb begin
      if (i_count < i_bounds.b) begin
         o_kind = vsda_pkg::VSDA_K_INVALID;
      end else if (i_active) begin
         if (i_count < i_bounds.c) begin
            o_kind = vsda_pkg::VSDA_K_ONE;
         end else if (i_count < i_bounds.d) begin
            o_kind = vsda_pkg::VSDA_K_ZERO;
         end else if (i_count < i_bounds.e) begin
            o_kind = vsda_pkg::VSDA_K_SOF;
         end else begin
            o_kind = vsda_pkg::VSDA_K_BREAK;
         end
      end else begin
         if (i_count < i_bounds.c) begin
            o_kind = vsda_pkg::VSDA_K_ZERO;
         end else if (i_count < i_bounds.d) begin
            o_kind = vsda_pkg::VSDA_K_ONE;
         end else if (i_count < i_bounds.e) begin
            o_kind = vsda_pkg::VSDA_K_EOD;
         end else if (i_count < i_bounds.f) begin
            o_kind = vsda_pkg::VSDA_K_EOF;
         end else if (i_count < i_bounds.g) begin
            o_kind = vsda_pkg::VSDA_K_EOF_IFS;
         end else begin
            o_kind = vsda_pkg::VSDA_K_IDLE;
         end
      end
   end

endmodule

// >>> logic/vsda_line_sync.sv
// two-stage synchroniser for the sensed bus level with edge detection
`timescale 1ns/1ps
module vsda_line_sync (
   input  wire logic i_clock,   // system clock
   input  wire logic i_rst_n,   // synchronous reset, active low
   input  wire logic i_line,    // raw bus level, 1 = active
   output logic      o_level,   // synchronised level
   output logic      o_rise,    // passive to active, one cycle
   output logic      o_fall     // active to passive, one cycle
);

   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else begin
         meta   <= i_line;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign o_level = stable;
   assign o_rise  = stable & ~prev;
   assign o_fall  = ~stable & prev;

endmodule

// >>> logic/vsda_link_controller.sv
// vpw bus symbol decode, bitwise arbitration and automatic retry
//
// Notes on behaviour
// - band edges abut with no gap
// - passive period: invalid, zero, one, EOD
// - passive edge in next band: EOF
// - edge in band after EOF: EOF+IFS
// - no edge by IFS end: idle, send
// - edge after valid EOF starts pending frame
// - active period: invalid, one, zero, SOF
// - overlong active period is a BREAK
// - full IFS after BREAK before sending
// - busy bus: hold frame until idle
// - arbitration from first bit after SOF
// - zero dominant; loser stops driving at once
// - read-back mismatch stops sending, save at a late last bit
// - late last-bit mismatch appends two ones
// - second one dropped if first loses
// - lost frame resent after valid EOF
// - retries are unlimited
// - bits 64/128 us, level sets meaning
// - SOF is 200 us active
// - IFS is 300 us passive
// - BREAK is 239 us or more active
`timescale 1ns/1ps
module vsda_link_controller #(
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_BND_E_CYC = vsda_pkg::VSDA_BND_E_CYC,  // EOF / BREAK edge
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_BND_F_CYC = vsda_pkg::VSDA_BND_F_CYC,  // IFS band edge
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_BND_G_CYC = vsda_pkg::VSDA_BND_G_CYC,  // idle edge
   parameter logic [vsda_pkg::VSDA_CNT_W-1:0] P_SOF_CYC   = vsda_pkg::VSDA_SOF_CYC     // sent SOF length
) (
   input  wire logic                      i_clock,        // system clock, 25 MHz
   input  wire logic                      i_rst_n,        // synchronous reset, active low
   input  wire logic                      i_bus_line,     // sensed bus level, 1 = active
   output logic                           o_bus_drive,    // drive bus active
   input  wire logic                      i_load_valid,   // frame byte offered
   input  wire logic [7:0]                i_load_data,    // frame byte, msb sent first
   input  wire logic                      i_load_last,    // byte closes the frame
   output logic                           o_load_ready,   // byte accepted when valid
   input  wire logic                      i_abort_retry,  // terminate auto retry, pulse
   output vsda_pkg::vsda_rx_sym_type      o_rx_sym,       // classified symbol, pulse
   output logic                           o_bus_idle,     // bus idle level
   output logic                           o_tx_busy,      // frame held or on the bus
   output logic                           o_tx_done,      // frame sent, pulse
   output logic                           o_tx_lost       // attempt lost, pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // bus sensing and period measurement

   logic                                  level;
   logic                                  rise;
   logic                                  fall;
   logic                                  edge_seen;
   logic [vsda_pkg::VSDA_CNT_W-1:0]       cnt;
   vsda_pkg::vsda_bounds_type             bounds;
   vsda_pkg::vsda_kind_type               kind;
   logic                                  brk_now;
   logic                                  idle_now;
   logic                                  eof_edge;

   vsda_line_sync u_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_line  (i_bus_line),
      .o_level (level),
      .o_rise  (rise),
      .o_fall  (fall)
   );

   assign edge_seen = rise | fall;

   assign bounds = '{
      b: vsda_pkg::VSDA_BND_B_CYC,
      c: vsda_pkg::VSDA_BND_C_CYC,
      d: vsda_pkg::VSDA_BND_D_CYC,
      e: P_BND_E_CYC,
      f: P_BND_F_CYC,
      g: P_BND_G_CYC
   };

   // saturates so a long idle never wraps into a data band
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cnt <= '0;
      end else if (edge_seen) begin
         cnt <= '0;
      end else if (cnt != '1) begin
         cnt <= cnt + 13'h0001;
      end
   end

   // a fall ends an active period
   vsda_band_classifier u_classify (
      .i_count  (cnt),
      .i_active (fall),
      .i_bounds (bounds),
      .o_kind   (kind)
   );

   assign brk_now  = level && (cnt == bounds.e);
   assign idle_now = !level && (cnt == bounds.g);
   assign eof_edge = rise && ((kind == vsda_pkg::VSDA_K_EOF) || (kind == vsda_pkg::VSDA_K_EOF_IFS));

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_rx_sym <= '{valid: 1'b0, kind: vsda_pkg::VSDA_K_INVALID};
      end else if (edge_seen) begin
         o_rx_sym <= '{valid: 1'b1, kind: kind};
      end else if (brk_now) begin
         o_rx_sym <= '{valid: 1'b1, kind: vsda_pkg::VSDA_K_BREAK};
      end else if (idle_now) begin
         o_rx_sym <= '{valid: 1'b1, kind: vsda_pkg::VSDA_K_IDLE};
      end else begin
         o_rx_sym <= '{valid: 1'b0, kind: o_rx_sym.kind};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus state flags

   logic bus_idle;
   logic after_break;

   // idle unknown after reset: wait a full quiet IFS
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         bus_idle <= 1'b0;
      end else if (rise) begin
         bus_idle <= 1'b0;
      end else if (idle_now) begin
         bus_idle <= 1'b1;
      end
   end

   // after a BREAK, no edge join until a whole IFS passes
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         after_break <= 1'b0;
      end else if (brk_now) begin
         after_break <= 1'b1;
      end else if (idle_now) begin
         after_break <= 1'b0;
      end
   end

   assign o_bus_idle = bus_idle;

   ////////////////////////////////////////////////////////////////////////////
   // frame store, kept whole for resending

   logic [7:0]                            frame_mem [vsda_pkg::VSDA_FRAME_BYTES];
   logic [3:0]                            load_idx;
   logic [3:0]                            last_idx;
   logic                                  load_fin;
   vsda_pkg::vsda_state_type              state;

   assign o_load_ready = (state == vsda_pkg::VSDA_ST_IDLE);
   assign load_fin     = i_load_valid && o_load_ready &&
                         (i_load_last || (load_idx == 4'(vsda_pkg::VSDA_FRAME_BYTES - 1)));

   always_ff @(posedge i_clock) begin
      if (i_load_valid && o_load_ready) begin
         frame_mem[load_idx] <= i_load_data;
      end
   end

   // an overlong frame closes at the last slot
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         load_idx <= 4'h0;
         last_idx <= 4'h0;
      end else if (load_fin) begin
         load_idx <= 4'h0;
         last_idx <= load_idx;
      end else if (i_load_valid && o_load_ready) begin
         load_idx <= load_idx + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit and arbitration

   logic [3:0]                            byte_idx;
   logic [2:0]                            bit_idx;
   logic                                  ext_second;
   logic                                  abort_req;
   logic                                  in_tx;
   logic                                  tx_bit;
   logic                                  rx_is_bit;
   logic                                  bit_match;
   logic                                  last_bit;
   logic                                  extra_ok;
   logic                                  sof_start;
   logic                                  lose;
   logic                                  done_now;
   logic                                  to_extra;

   assign in_tx = (state == vsda_pkg::VSDA_ST_SOF) || (state == vsda_pkg::VSDA_ST_DATA) ||
                  (state == vsda_pkg::VSDA_ST_EXTRA);
   assign tx_bit = (state == vsda_pkg::VSDA_ST_EXTRA) ? 1'b1 : frame_mem[byte_idx][bit_idx];
   assign rx_is_bit = (kind == vsda_pkg::VSDA_K_ZERO) || (kind == vsda_pkg::VSDA_K_ONE);
   assign bit_match = rx_is_bit && ((kind == vsda_pkg::VSDA_K_ONE) == tx_bit);
   assign last_bit  = (byte_idx == last_idx) && (bit_idx == 3'h0);
   assign extra_ok  = (bit_idx == 3'h0) && (byte_idx >= 4'(vsda_pkg::VSDA_EXTRA_BYTE));

   // start on a quiet bus or join a frame opened after EOF
   assign sof_start = (state == vsda_pkg::VSDA_ST_WAIT) && !abort_req &&
                      (bus_idle || (eof_edge && !after_break));

   assign done_now = (state == vsda_pkg::VSDA_ST_DATA) && edge_seen && bit_match && last_bit && !brk_now;
   assign to_extra = (state == vsda_pkg::VSDA_ST_DATA) && edge_seen && !bit_match && extra_ok && !brk_now;

   always_comb begin
      lose = 1'b0;
      if (in_tx && brk_now) begin
         lose = 1'b1;
      end else if ((state == vsda_pkg::VSDA_ST_SOF) && fall && (kind != vsda_pkg::VSDA_K_SOF)) begin
         lose = 1'b1;
      end else if ((state == vsda_pkg::VSDA_ST_DATA) && edge_seen && !bit_match && !extra_ok) begin
         lose = 1'b1;
      end else if ((state == vsda_pkg::VSDA_ST_EXTRA) && edge_seen && (!bit_match || ext_second)) begin
         lose = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state <= vsda_pkg::VSDA_ST_IDLE;
      end else begin
         case (state)
            vsda_pkg::VSDA_ST_IDLE: begin
               if (load_fin) begin
                  state <= vsda_pkg::VSDA_ST_WAIT;
               end
            end
            vsda_pkg::VSDA_ST_WAIT: begin
               if (abort_req) begin
                  state <= vsda_pkg::VSDA_ST_IDLE;
               end else if (sof_start) begin
                  state <= vsda_pkg::VSDA_ST_SOF;
               end
            end
            vsda_pkg::VSDA_ST_SOF: begin
               if (lose) begin
                  state <= vsda_pkg::VSDA_ST_WAIT;
               end else if (fall) begin
                  state <= vsda_pkg::VSDA_ST_DATA;
               end
            end
            vsda_pkg::VSDA_ST_DATA: begin
               if (lose) begin
                  state <= vsda_pkg::VSDA_ST_WAIT;
               end else if (done_now) begin
                  state <= vsda_pkg::VSDA_ST_IDLE;
               end else if (to_extra) begin
                  state <= vsda_pkg::VSDA_ST_EXTRA;
               end
            end
            vsda_pkg::VSDA_ST_EXTRA: begin
               if (lose) begin
                  state <= vsda_pkg::VSDA_ST_WAIT;
               end
            end
            default: begin
               state <= vsda_pkg::VSDA_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         byte_idx   <= 4'h0;
         bit_idx    <= 3'h7;
         ext_second <= 1'b0;
      end else if (sof_start) begin
         byte_idx   <= 4'h0;
         bit_idx    <= 3'h7;
         ext_second <= 1'b0;
      end else if ((state == vsda_pkg::VSDA_ST_DATA) && edge_seen && bit_match && !last_bit) begin
         bit_idx <= bit_idx - 3'h1;
         if (bit_idx == 3'h0) begin
            byte_idx <= byte_idx + 4'h1;
         end
      end else if ((state == vsda_pkg::VSDA_ST_EXTRA) && edge_seen && bit_match) begin
         ext_second <= 1'b1;
      end
   end

   // an abort during an attempt lets it finish, then drops the retry
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         abort_req <= 1'b0;
      end else if (state == vsda_pkg::VSDA_ST_IDLE) begin
         abort_req <= 1'b0;
      end else if (i_abort_retry) begin
         abort_req <= 1'b1;
      end
   end

   // an edge starts a phase at the sensed level;
   // between edges the counter times the symbol
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_bus_drive <= 1'b0;
      end else if (lose || done_now || !in_tx) begin
         o_bus_drive <= 1'b0;
      end else if (state == vsda_pkg::VSDA_ST_SOF) begin
         o_bus_drive <= edge_seen ? level : (!level || (cnt < P_SOF_CYC));
      end else if (edge_seen) begin
         o_bus_drive <= level;
      end else if (level) begin
         o_bus_drive <= cnt < vsda_pkg::vsda_nominal(tx_bit, 1'b1);
      end else begin
         o_bus_drive <= cnt >= vsda_pkg::vsda_nominal(tx_bit, 1'b0);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_tx_done <= 1'b0;
         o_tx_lost <= 1'b0;
      end else begin
         o_tx_done <= done_now;
         o_tx_lost <= lose;
      end
   end

   assign o_tx_busy = (state != vsda_pkg::VSDA_ST_IDLE);

endmodule
